// ### asc_defs.vh
// Constants for the converter sequencer control block: offsets, fields, resets, codes.
// Assumes a 32-bit APB slave with one aligned word per register.
// Summary of operation
// - Watchdog enable turns result comparison on
// - Sync field codes free, parallel, fast, slow
// - Sync field acts only in first converter
// - Discontinuous burst converts count plus one
// - Discontinuous enable picks burst or normal sequencing
// - Single-channel bit limits watchdog to selection in scan mode
// - Scan bit enables stepping channel list
// - Watchdog interrupt enable gates watchdog flag
// - Done interrupt enable gates done flag
// - Watchdog channel field selects 0 to 17
// - First converter routes 16/17 internally
// - Control register resets to all zeros
// - Out-of-window result sets watchdog flag
// - Sequence completion sets done flag
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH
`define ASC_OFF_STATUS 12'h000
`define ASC_OFF_CTRL0 12'h004
`define ASC_OFF_LOW_THR 12'h024
`define ASC_OFF_HIGH_THR 12'h028
`define ASC_OFF_SEQ_LEN 12'h02C
`define ASC_OFF_CH_LIST 12'h030
`define ASC_OFF_CMD 12'h034
`define ASC_OFF_STATE 12'h038
`define ASC_CTRL0_RESET 32'h00000000
`define ASC_CTRL0_WMASK 32'h008FEB7F
`define ASC_BIT_WD_EN 23
`define ASC_SYNC_HI 19
`define ASC_SYNC_LO 16
`define ASC_DISC_HI 15
`define ASC_DISC_LO 13
`define ASC_BIT_DISC_EN 11
`define ASC_BIT_WD_SINGLE 9
`define ASC_BIT_SCAN 8
`define ASC_BIT_WD_IE 6
`define ASC_BIT_EOC_IE 5
`define ASC_WDCH_HI 4
`define ASC_WDCH_LO 0
`define ASC_BIT_EOC 1
`define ASC_BIT_WDE 0
`define ASC_SYNC_FREE 4'h0
`define ASC_SYNC_PARALLEL 4'h6
`define ASC_SYNC_FAST 4'h7
`define ASC_SYNC_SLOW 4'h8
`define ASC_CH_MAX 5'h11
`define ASC_CH_TEMP 5'h10
`define ASC_CH_VREF 5'h11
`endif

// ### asc_wdog_cmp.v
// Watchdog window comparator for one converted result.
// Assumes thresholds are stable while results arrive.
`timescale 1ns/100ps
`include "asc_defs.vh"
module asc_wdog_cmp #(
	parameter DW = 12
)(
	input wire i_enable, // Watchdog enabled
	input wire i_single, // Single-channel watchdog
	input wire i_scan, // Scan mode active
	input wire [4:0] i_sel_ch, // Watched channel
	input wire [4:0] i_res_ch, // Channel of result
	input wire [DW-1:0] i_result, // Converted value
	input wire [DW-1:0] i_low, // Low threshold
	input wire [DW-1:0] i_high, // High threshold
	output wire o_hit // Out of window, qualified
);
	wire chan_ok;
	// Single-channel restriction only meaningful in scan mode; else the one channel converted
	assign chan_ok = (i_scan && !i_single) || (i_res_ch == i_sel_ch) || !i_scan;
	assign o_hit = i_enable && chan_ok && ((i_result < i_low) || (i_result > i_high));
endmodule

// ### asc_seq_step.v
// Sequence step counter: tracks position in list and burst length.
// Assumes a one-cycle step pulse per completed conversion.
`timescale 1ns/100ps
module asc_seq_step (
	input wire i_clk, // Clock
	input wire i_reset_n, // Async reset, active low
	input wire i_ce, // Clock enable
	input wire i_clear, // Restart at list head
	input wire i_step, // One conversion done
	input wire [3:0] i_len_m1, // Sequence length minus one
	input wire [2:0] i_disc_m1, // Burst length minus one
	input wire i_disc_en, // Discontinuous on
	output wire [3:0] o_pos, // Current list slot
	output wire o_seq_end, // Step ends sequence
	output wire o_burst_end // Step ends burst
);
	reg [3:0] pos_q;
	reg [2:0] burst_q;
	assign o_pos = pos_q;
	assign o_seq_end = i_step && (pos_q == i_len_m1);
	assign o_burst_end = i_step && (o_seq_end || (i_disc_en && (burst_q == i_disc_m1)));
	// Position and burst counters; burst restarts at each burst end
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pos_q <= 4'h0;
			burst_q <= 3'h0;
		end
		else if (i_ce)
		begin
			if (i_clear || o_seq_end)
				pos_q <= 4'h0;
			else if (i_step)
				pos_q <= pos_q + 4'h1;
			if (i_clear || o_burst_end)
				burst_q <= 3'h0;
			else if (i_step)
				burst_q <= burst_q + 3'h1;
		end
	end
endmodule

// ### asc_ctrl_top.v
// Converter sequencer control: APB register file, sequencer, watchdog, interrupt.
// Assumes an analog core that takes a start pulse and a channel, then returns
// a result with a done pulse; APB master follows the usual two-phase protocol.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`include "asc_defs.vh"
module asc_ctrl_top #(
	parameter DW = 12,
	parameter IS_FIRST = 1
)(
	input wire i_clk, // 100 MHz clock
	input wire i_reset_n, // Async reset, active low
	input wire i_ce, // Clock enable, freezes state
	input wire i_psel, // APB select
	input wire i_penable, // APB enable
	input wire i_pwrite, // APB write
	input wire [11:0] i_paddr, // APB byte address
	input wire [31:0] i_pwdata, // APB write data
	output reg [31:0] o_prdata, // APB read data
	output reg o_pready, // APB ready
	output reg o_pslverr, // APB error
	input wire i_trigger, // Sequence trigger pulse
	input wire i_conv_done, // Core finished conversion
	input wire [DW-1:0] i_conv_result, // Core result
	output reg o_conv_start, // Start one conversion
	output reg [4:0] o_conv_ch, // Channel to convert
	output reg o_ch_internal, // Channel routed to internal source
	output reg [3:0] o_sync_mode, // Sync mode toward partner
	output reg o_irq // Interrupt request
);
	localparam ST_IDLE = 2'h0;
	localparam ST_START = 2'h1;
	localparam ST_WAIT = 2'h2;
	reg [31:0] ctrl0_q;
	reg [1:0] stat_q;
	reg [DW-1:0] low_q;
	reg [DW-1:0] high_q;
	reg [3:0] len_q;
	reg [4:0] list_q [0:15];
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg armed_q;
	reg [DW-1:0] last_q;
	reg [4:0] cur_ch_q;
	wire wr_acc;
	wire rd_acc;
	wire [3:0] pos;
	wire seq_end;
	wire burst_end;
	wire wd_hit;
	wire step;
	wire scan_on;
	wire [3:0] len_eff;
	wire clear_seq;
	integer k;

	// Valid sync code check, used only for the sync mode output
	function sync_valid;
		input [3:0] code;
		begin
			sync_valid = (code == `ASC_SYNC_FREE) || (code == `ASC_SYNC_PARALLEL) ||
				(code == `ASC_SYNC_FAST) || (code == `ASC_SYNC_SLOW);
		end
	endfunction

	// Legal channel number check
	function ch_valid;
		input [4:0] ch;
		begin
			ch_valid = (ch <= `ASC_CH_MAX);
		end
	endfunction

	// Zero-wait APB: access taken when psel and penable both high
	assign wr_acc = i_psel && i_penable && i_pwrite && o_pready;
	assign rd_acc = i_psel && i_penable && !i_pwrite && o_pready;
	assign scan_on = ctrl0_q[`ASC_BIT_SCAN];
	// Without scan only list slot 0 is converted
	assign len_eff = scan_on ? len_q : 4'h0;
	assign step = (state_q == ST_WAIT) && i_conv_done;
	assign clear_seq = wr_acc && (i_paddr == `ASC_OFF_CMD) && i_pwdata[1];

	asc_seq_step u_step (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_ce(i_ce),
		.i_clear(clear_seq),
		.i_step(step),
		.i_len_m1(len_eff),
		.i_disc_m1(ctrl0_q[`ASC_DISC_HI:`ASC_DISC_LO]),
		.i_disc_en(ctrl0_q[`ASC_BIT_DISC_EN]),
		.o_pos(pos),
		.o_seq_end(seq_end),
		.o_burst_end(burst_end)
	);

	asc_wdog_cmp #(.DW(DW)) u_wdog (
		.i_enable(ctrl0_q[`ASC_BIT_WD_EN]),
		.i_single(ctrl0_q[`ASC_BIT_WD_SINGLE]),
		.i_scan(scan_on),
		.i_sel_ch(ctrl0_q[`ASC_WDCH_HI:`ASC_WDCH_LO]),
		.i_res_ch(cur_ch_q),
		.i_result(i_conv_result),
		.i_low(low_q),
		.i_high(high_q),
		.o_hit(wd_hit)
	);

	// Control register; reserved bits masked so they always read zero
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ctrl0_q <= `ASC_CTRL0_RESET;
		else if (i_ce && wr_acc && (i_paddr == `ASC_OFF_CTRL0))
			ctrl0_q <= i_pwdata & `ASC_CTRL0_WMASK;
	end

	// Thresholds, list length and channel list
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			low_q <= {DW{1'b0}};
			high_q <= {DW{1'b1}};
			len_q <= 4'h0;
			for (k = 0; k < 16; k = k + 1)
				list_q[k] <= 5'h00;
		end
		else if (i_ce && wr_acc)
		begin
			if (i_paddr == `ASC_OFF_LOW_THR)
				low_q <= i_pwdata[DW-1:0];
			if (i_paddr == `ASC_OFF_HIGH_THR)
				high_q <= i_pwdata[DW-1:0];
			if (i_paddr == `ASC_OFF_SEQ_LEN)
				len_q <= i_pwdata[3:0];
			// Slot index in bits 11:8, channel in 4:0; illegal channels dropped
			if ((i_paddr == `ASC_OFF_CH_LIST) && ch_valid(i_pwdata[4:0]))
				list_q[i_pwdata[11:8]] <= i_pwdata[4:0];
		end
	end

	// Sticky status; read clears, but a new event in the same cycle wins
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			stat_q <= 2'h0;
		else if (i_ce)
		begin
			if (rd_acc && (i_paddr == `ASC_OFF_STATUS))
				stat_q <= 2'h0;
			if (step && seq_end)
				stat_q[`ASC_BIT_EOC] <= 1'b1;
			if (step && wd_hit)
				stat_q[`ASC_BIT_WDE] <= 1'b1;
		end
	end

	// Sequencer next state
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
				if (i_trigger || armed_q)
					state_d = ST_START;
			ST_START:
				state_d = ST_WAIT;
			ST_WAIT:
				if (i_conv_done)
					state_d = (burst_end) ? ST_IDLE : ST_START;
			default:
				state_d = ST_IDLE;
		endcase
	end

	// Sequencer state, start pulse and channel; one trigger may queue while busy
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_q <= ST_IDLE;
			armed_q <= 1'b0;
			o_conv_start <= 1'b0;
			o_conv_ch <= 5'h00;
			cur_ch_q <= 5'h00;
			o_ch_internal <= 1'b0;
			last_q <= {DW{1'b0}};
		end
		else if (i_ce)
		begin
			state_q <= state_d;
			if (state_q == ST_IDLE)
				armed_q <= 1'b0;
			else if (i_trigger)
				armed_q <= 1'b1;
			o_conv_start <= (state_q == ST_START);
			if (state_q == ST_START)
			begin
				o_conv_ch <= list_q[pos];
				cur_ch_q <= list_q[pos];
				// Channels 16 and 17 go to sensor and reference only on the first unit
				o_ch_internal <= (IS_FIRST != 0) &&
					((list_q[pos] == `ASC_CH_TEMP) || (list_q[pos] == `ASC_CH_VREF));
			end
			if (step)
				last_q <= i_conv_result;
		end
	end

	// Sync mode drives partner only on first unit, and only for legal codes
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_sync_mode <= `ASC_SYNC_FREE;
		else if (i_ce)
		begin
			if ((IS_FIRST != 0) && sync_valid(ctrl0_q[`ASC_SYNC_HI:`ASC_SYNC_LO]))
				o_sync_mode <= ctrl0_q[`ASC_SYNC_HI:`ASC_SYNC_LO];
			else
				o_sync_mode <= `ASC_SYNC_FREE;
		end
	end

	// Interrupt: level while an enabled sticky flag is set
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_irq <= 1'b0;
		else if (i_ce)
			o_irq <= (stat_q[`ASC_BIT_WDE] && ctrl0_q[`ASC_BIT_WD_IE]) ||
				(stat_q[`ASC_BIT_EOC] && ctrl0_q[`ASC_BIT_EOC_IE]);
	end

	// APB answer; ready is high only in the cycle after each setup so data is registered
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
		end
		else if (i_ce)
		begin
			o_pready <= i_psel && !i_penable;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h00000000;
			if (i_psel && !i_penable)
			begin
				case (i_paddr)
					`ASC_OFF_STATUS: o_prdata <= {30'h00000000, stat_q};
					`ASC_OFF_CTRL0: o_prdata <= ctrl0_q;
					`ASC_OFF_LOW_THR: o_prdata <= {{(32-DW){1'b0}}, low_q};
					`ASC_OFF_HIGH_THR: o_prdata <= {{(32-DW){1'b0}}, high_q};
					`ASC_OFF_SEQ_LEN: o_prdata <= {28'h0000000, len_q};
					`ASC_OFF_CMD: o_prdata <= 32'h00000000;
					`ASC_OFF_STATE: o_prdata <= {{(26-DW){1'b0}}, last_q, pos, state_q};
					`ASC_OFF_CH_LIST: o_prdata <= 32'h00000000;
					default: o_pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ### asc_core_model.sv
// Behavioural analog core facing the sequencer.
// Assumes one start pulse per conversion; latency set by the bench.
`timescale 1ns/100ps
module asc_core_model (
	input wire logic i_clk, // Clock
	input wire logic i_reset_n, // Reset, active low
	input wire logic i_start, // Start pulse
	input wire logic [4:0] i_ch, // Channel
	input wire logic [3:0] i_lat, // Extra wait cycles
	output logic o_done, // Done pulse
	output logic [11:0] o_result, // Result
	output logic o_busy // Converting
);
	logic [3:0] cnt_q;
	logic [11:0] val_q;
	// Result is channel times 0x80, so each slot is recognisable
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			cnt_q <= 4'h0;
			val_q <= 12'h000;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_start)
			begin
				o_busy <= 1'b1;
				cnt_q <= i_lat;
				val_q <= {i_ch, 7'h00};
			end
			else if (o_busy && cnt_q == 4'h0)
			begin
				o_done <= 1'b1;
				o_busy <= 1'b0;
			end
			else if (o_busy)
				cnt_q <= cnt_q - 4'h1;
		end
	end
	// Outside done the bus shows the inverse, never a stale result
	assign o_result = o_done ? val_q : ~val_q;
endmodule

// ### asc_ctrl_assertions.sv
// Checker for the sequencer control block, bound to its top ports.
// Assumes a first-unit build and APB answers one cycle after setup.
`timescale 1ns/100ps
module asc_ctrl_checker #(
	parameter DW = 12
)(
	input wire logic i_clk, // Clock
	input wire logic i_reset_n, // Reset
	input wire logic i_psel, // Select
	input wire logic i_penable, // Access
	input wire logic i_pwrite, // Write
	input wire logic [11:0] i_paddr, // Address
	input wire logic [31:0] i_pwdata, // Write data
	input wire logic o_pready, // Ready
	input wire logic o_conv_start, // Start
	input wire logic [4:0] o_conv_ch, // Channel
	input wire logic o_ch_internal, // Internal source
	input wire logic [3:0] o_sync_mode, // Sync code
	input wire logic o_irq // Interrupt
);
	logic [1:0] ie_q;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// Shadow of the interrupt enables, taken at the completing edge
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ie_q <= 2'h0;
		else if (i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h004)
			ie_q <= i_pwdata[6:5];
	end
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_ctrl_wr;
		i_psel && i_penable && o_pready && i_pwrite && i_paddr == 12'h004;
	endsequence
	property p_ready_once;
		s_setup |=> o_pready ##1 !o_pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("ready timing wrong");
	property p_start_pulse;
		o_conv_start |=> !o_conv_start;
	endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
	property p_internal;
		o_conv_start |-> o_ch_internal == (o_conv_ch >= 5'h10);
	endproperty
	a_internal: assert property (p_internal) else $error("internal routing wrong");
	property p_ch_range;
		o_conv_start |-> o_conv_ch <= 5'h11;
	endproperty
	a_ch_range: assert property (p_ch_range) else $error("channel out of range");
	property p_sync_legal;
		o_sync_mode inside {4'h0, 4'h6, 4'h7, 4'h8};
	endproperty
	a_sync_legal: assert property (p_sync_legal) else $error("sync code illegal");
	property p_sync_follow;
		s_ctrl_wr |-> ##2 o_sync_mode == (($past(i_pwdata[19:16], 2) inside {4'h6, 4'h7, 4'h8}) ?
			$past(i_pwdata[19:16], 2) : 4'h0);
	endproperty
	a_sync_follow: assert property (p_sync_follow) else $error("sync not applied");
	property p_irq_gate;
		o_irq |-> $past(ie_q) != 2'h0;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
	property p_irq_off;
		s_ctrl_wr ##0 (i_pwdata[6:5] == 2'h0) |-> ##2 !o_irq;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq after disable");
endmodule
bind asc_ctrl_top asc_ctrl_checker #(.DW(DW)) u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
	.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
	.o_pready(o_pready), .o_conv_start(o_conv_start), .o_conv_ch(o_conv_ch),
	.o_ch_internal(o_ch_internal), .o_sync_mode(o_sync_mode), .o_irq(o_irq));

// ### asc_ctrl_top_tb.sv
// Self-checking bench: APB register tests and sequencer runs.
// Assumes the core model answers every start with one done pulse.
`timescale 1ns/100ps
`include "asc_defs.vh"
module asc_ctrl_top_tb;
	logic i_clk = 0, i_reset_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_trigger = 0, i_ce = 1;
	logic [11:0] i_paddr = 12'h000, i_conv_result;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rdat;
	logic o_pready, o_pslverr, i_conv_done, o_conv_start, o_ch_internal, o_irq, busy, err_q;
	logic [4:0] o_conv_ch;
	logic [3:0] o_sync_mode, lat = 4'h1;
	logic [3:0] codes [4] = '{4'h6, 4'h7, 4'h8, 4'h0};
	int nst = 0, n_errors = 0, num_checks = 0, nint = 0, nbase = 0;
	asc_ctrl_top u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(i_ce), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_trigger(i_trigger),
		.i_conv_done(i_conv_done), .i_conv_result(i_conv_result), .o_conv_start(o_conv_start),
		.o_conv_ch(o_conv_ch), .o_ch_internal(o_ch_internal), .o_sync_mode(o_sync_mode), .o_irq(o_irq));
	asc_core_model u_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_start(o_conv_start), .i_ch(o_conv_ch),
		.i_lat(lat), .o_done(i_conv_done), .o_result(i_conv_result), .o_busy(busy));
	always #5 i_clk = ~i_clk;
	// Count conversions requested by the sequencer
	always @(posedge i_clk)
		if (o_conv_start === 1'b1)
			nst <= nst + 1;
	// Count conversions routed to an internal source
	always @(posedge i_clk)
		if (o_conv_start === 1'b1 && o_ch_internal === 1'b1)
			nint <= nint + 1;
	task automatic print_verdict();
		begin
			$display("checks %0d errors %0d", num_checks, n_errors);
			if (n_errors == 0 && num_checks > 0)
				$display("bench passed");
			else
				$display("bench failed");
			$finish;
		end
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			num_checks++;
			if (got !== exp)
			begin
				n_errors++;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One APB transfer; request held until ready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		begin
			i_psel <= 1'b1;
			i_pwrite <= w;
			i_paddr <= a;
			i_pwdata <= d;
			@(posedge i_clk);
			i_penable <= 1'b1;
			k = 0;
			do
			begin
				@(posedge i_clk);
				k++;
			end
			while (o_pready !== 1'b1 && k < 20);
			rdat = o_prdata;
			err_q = o_pslverr;
			i_psel <= 1'b0;
			i_penable <= 1'b0;
			@(posedge i_clk);
			if (k >= 20)
			begin
				n_errors++;
				print_verdict();
			end
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		begin
			apb(1'b0, a, 32'h0);
			chk(rdat, exp);
		end
	endtask
	// Trigger once and wait for n conversions to finish
	task automatic run(input int n);
		int k;
		int n0;
		begin
			n0 = nst;
			i_trigger <= 1'b1;
			@(posedge i_clk);
			i_trigger <= 1'b0;
			for (k = 0; k < 300 && !(nst - n0 == n && busy === 1'b0); k++)
				@(posedge i_clk);
			repeat (3) @(posedge i_clk);
			chk(nst - n0, n);
			if (k >= 300)
			begin
				n_errors++;
				print_verdict();
			end
		end
	endtask
	initial
	begin
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd(`ASC_OFF_CTRL0, `ASC_CTRL0_RESET);
		chk(o_irq, 32'h0);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h0080EB7F);
		rd(`ASC_OFF_CTRL0, 32'h0080EB7F);
		rd(12'h0FC, 32'h0);
		chk(err_q, 32'h1);
		// Sync codes in turn, ending in free mode before other changes
		foreach (codes[i])
		begin
			apb(1'b1, `ASC_OFF_CTRL0, {12'h000, codes[i], 16'h0000});
			repeat (2) @(posedge i_clk);
			chk(o_sync_mode, codes[i]);
		end
		// Reserved sync code must leave the partner in free mode
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00030000);
		repeat (2) @(posedge i_clk);
		chk(o_sync_mode, 32'h0);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00000000);
		apb(1'b1, `ASC_OFF_LOW_THR, 32'h100);
		apb(1'b1, `ASC_OFF_HIGH_THR, 32'h300);
		apb(1'b1, `ASC_OFF_SEQ_LEN, 32'h3);
		apb(1'b1, `ASC_OFF_CH_LIST, 32'h002);
		apb(1'b1, `ASC_OFF_CH_LIST, 32'h110);
		apb(1'b1, `ASC_OFF_CH_LIST, 32'h211);
		apb(1'b1, `ASC_OFF_CH_LIST, 32'h305);
		apb(1'b1, `ASC_OFF_CH_LIST, 32'h312);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00002920);
		run(2);
		rd(`ASC_OFF_STATUS, 32'h0);
		chk(o_irq, 32'h0);
		lat <= 4'h6;
		run(2);
		chk(o_irq, 32'h1);
		rd(`ASC_OFF_STATUS, 32'h2);
		repeat (2) @(posedge i_clk);
		chk(o_irq, 32'h0);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00800345);
		run(4);
		rd(`ASC_OFF_STATUS, 32'h2);
		chk(o_irq, 32'h0);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00800140);
		run(4);
		chk(o_irq, 32'h1);
		rd(`ASC_OFF_STATUS, 32'h3);
		// Clock enable low: a trigger must not start anything
		i_ce <= 1'b0;
		nbase = nst;
		i_trigger <= 1'b1;
		@(posedge i_clk);
		i_trigger <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk(nst - nbase, 0);
		i_ce <= 1'b1;
		@(posedge i_clk);
		apb(1'b1, `ASC_OFF_CTRL0, 32'h00800000);
		run(1);
		chk(nint, 6);
		print_verdict();
	end
endmodule
